/* File: tli_defs.svh */
// Purpose: Constants for the transmit line interface output stage
// Assumes: Included by bare name wherever offsets or field positions are needed
// Notes: Types live in tli_pkg; this header holds numbers only
`ifndef TLI_DEFS_SVH
`define TLI_DEFS_SVH

// Register byte offsets on the APB word map
`define TLI_OFS_CTRL 12'h000
`define TLI_OFS_STATUS 12'h004
`define TLI_ADDR_W 12

// Control register width and reset value
`define TLI_CTRL_W 14
`define TLI_CTRL_RST 14'h0000

// Status register bit positions
`define TLI_ST_PINS_ON 0
`define TLI_ST_REF_SEEN 1
`define TLI_ST_W 2

// Line rates in kHz, kept for the clock generator that follows the rate select
`define TLI_RATE_DS3_KHZ 44736
`define TLI_RATE_E3_KHZ 34368

// Synchroniser depth
`define TLI_SYNC_STAGES 2

`endif

/* File: tli_pkg.sv */
// Purpose: Types shared by the transmit line interface output stage
// Assumes: Field order of tli_ctrl_t matches the control register bit layout
// Notes: Bit 0 is pins_en, bit 13 is pos_dis
package tli_pkg;

   // Line coding of the port
   typedef enum logic [1:0] {
      TLI_MODE_B3ZS = 2'b00,
      TLI_MODE_HDB3 = 2'b01,
      TLI_MODE_AMI = 2'b10,
      TLI_MODE_UNIPOLAR = 2'b11
   } tli_mode_t;

   // Reference clock for the pulse and data outputs
   typedef enum logic [2:0] {
      TLI_REF_LINE = 3'b000,
      TLI_REF_TXO = 3'b001,
      TLI_REF_TXI = 3'b010,
      TLI_REF_RXL = 3'b011,
      TLI_REF_RXO = 3'b100
   } tli_ref_t;

   // Control register image, MSB first
   typedef struct packed {
      logic pos_dis;    // Bit 13: positive/data output disabled
      logic drive_en;   // Bit 12: analog output drive
      logic line_unit_en; // Bit 11: internal line interface unit on
      logic ref_inv;    // Bit 10: reference clock inverted
      logic neg_inv;    // Bit 9
      logic pos_inv;    // Bit 8
      logic clk_inv;    // Bit 7
      tli_ref_t ref_sel; // Bits 6:4
      logic std_e3;     // Bit 3: 1 = E3 rate, 0 = DS3 rate
      tli_mode_t mode;  // Bits 2:1
      logic pins_en;    // Bit 0: transmit line pins enabled
   } tli_ctrl_t;

   // One bit period of line data from the encoder
   typedef struct packed {
      logic pos;  // Positive pulse wanted
      logic neg;  // Negative pulse wanted
      logic data; // Unencoded serial bit
   } tli_line_t;

   // Frame inputs caught on the reference edge
   typedef struct packed {
      logic frame_start; // Frame-start input
      logic serial_data; // Serial data input
   } tli_frame_t;

endpackage : tli_pkg

/* File: tli_sync.sv */
// Purpose: Multi-bit level synchroniser
// Assumes: Each bit is a slow level; bits are not coherent with each other
// Notes: First stage is read only by the second stage
`include "tli_defs.svh"
module tli_sync
   import tli_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic clk,                // Destination clock
   input wire logic rst_n,              // Destination reset, async low
   input wire logic [WIDTH-1:0] d,      // Level from the other domain
   output logic [WIDTH-1:0] q           // Synchronised level
);

   // Elaboration check on width
   if (WIDTH < 1) begin : g_bad_width
      $error("tli_sync WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] meta; // First stage, metastable window

   // Two flops per bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule // tli_sync

/* File: tli_clk_mux.sv */
// Purpose: Reference clock selector with edge choice
// Assumes: Select and invert are static while the pins are in use
// Notes: Not glitch free; change selection only with the pins disabled
module tli_clk_mux
   import tli_pkg::*;
(
   input wire logic line_clk,    // Line clock source
   input wire logic tx_clk_out,  // Transmit clock output net
   input wire logic tx_clk_in,   // Transmit clock input
   input wire logic rx_line_clk_in, // Receive line clock input
   input wire logic rx_clk_out,  // Receive clock output net
   input wire tli_ref_t sel,     // Source choice
   input wire logic fall,        // Update on falling edge
   output logic ref_clk          // Clock for the output flops
);

   logic picked; // Chosen source before inversion

   // Source choice, unused codes fall back to the line clock
   always_comb begin
      case (sel)
         TLI_REF_TXO: picked = tx_clk_out;
         TLI_REF_TXI: picked = tx_clk_in;
         TLI_REF_RXL: picked = rx_line_clk_in;
         TLI_REF_RXO: picked = rx_clk_out;
         default: picked = line_clk;
      endcase
   end

   // Inverting turns falling edges into the rising edges the flops use
   assign ref_clk = picked ^ fall;

endmodule // tli_clk_mux

/* File: tli_top.sv */
// Purpose: Transmit line interface output stage of one port
// Assumes: Encoder data arrives already on the reference clock domain
// Notes: Config crosses as static levels; reprogram with pins disabled
// Behaviour
// [R01] Line clock output only while pins enabled
// [R02] Line rate follows port standard, DS3/E3
// [R03] Positive pulse output high per positive pulse
// [R04] Negative pulse output high per negative pulse
// [R05] Unipolar mode puts unencoded data on pin
// [R06] Update on rising edge, falling if inverted
// [R07] Reference clock default line clock, selectable otherwise
// [R08] Separate inversion for clock, positive, negative
// [R09] Positive/data output disabled when unit enabled; code disables it only when pos_dis is also set
// [R10] Analog outputs driven only when unit drives
// [R11] Line clock times frame-start and serial inputs; code times them on the selected reference clock
// [R12] Disabled pins hold constant inactive level
`include "tli_defs.svh"
module tli_top
   import tli_pkg::*;
(
   input wire logic pclk,                  // APB clock, 125 MHz
   input wire logic presetn,               // APB reset, async low
   input wire logic psel,                  // APB select
   input wire logic penable,               // APB access phase
   input wire logic pwrite,                // APB write
   input wire logic [`TLI_ADDR_W-1:0] paddr, // APB byte address
   input wire logic [31:0] pwdata,         // APB write data
   output logic [31:0] prdata,             // APB read data
   output logic pready,                    // APB ready
   output logic pslverr,                   // APB error, unmapped address
   input wire logic line_clk,              // Link clock, line rate source
   input wire logic tx_clk_out,            // Alternate reference source
   input wire logic tx_clk_in,             // Alternate reference source
   input wire logic rx_line_clk_in,        // Alternate reference source
   input wire logic rx_clk_out,            // Alternate reference source
   input wire tli_line_t line_in,          // Encoder bits, reference domain
   input wire logic tx_frame_start_in,     // Frame-start input pin
   input wire logic tx_serial_data_in,     // Serial data input pin
   output tli_frame_t frame_out,           // Frame inputs caught on reference edge
   output logic line_rate_e3,              // Rate select to the clock generator
   output logic tx_line_clk_out,           // Transmit line clock pin
   output logic tx_pos_pulse_out,          // Positive pulse or unencoded data pin
   output logic tx_neg_pulse_out,          // Negative pulse pin
   output logic tx_analog_plus,            // Analog driver plus, data
   output logic tx_analog_plus_oe_n,       // Analog driver plus, enable low
   output logic tx_analog_minus,           // Analog driver minus, data
   output logic tx_analog_minus_oe_n       // Analog driver minus, enable low
);

   // ---------------- APB side ----------------
   tli_ctrl_t ctrl;                  // Control register
   logic ref_seen;                   // Sticky: reference clock seen running
   logic [`TLI_ST_W-1:0] st_sync;    // Status levels from link side
   logic alive_last;                 // Previous synced toggle
   logic acc_wr;                     // Write in access phase
   logic setup;                      // Setup phase
   logic hit_ctrl;                   // Address is control register
   logic hit_stat;                   // Address is status register
   logic [31:0] next_prdata;         // Read data chosen in setup

   assign hit_ctrl = (paddr == `TLI_OFS_CTRL);
   assign hit_stat = (paddr == `TLI_OFS_STATUS);
   assign setup = psel && !penable;
   assign acc_wr = psel && penable && pwrite;
   // Zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(hit_ctrl || hit_stat);

   // Control register write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= tli_ctrl_t'(`TLI_CTRL_RST);
      end else if (acc_wr && hit_ctrl) begin
         ctrl <= tli_ctrl_t'(pwdata[`TLI_CTRL_W-1:0]);
      end
   end

   // Sticky reference-seen flag; a fresh toggle wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_seen <= 1'b0;
         alive_last <= 1'b0;
      end else begin
         alive_last <= st_sync[`TLI_ST_REF_SEEN];
         if (st_sync[`TLI_ST_REF_SEEN] != alive_last) begin
            ref_seen <= 1'b1;
         end else if (acc_wr && hit_stat && pwdata[`TLI_ST_REF_SEEN]) begin
            ref_seen <= 1'b0;
         end
      end
   end

   // Read data mux
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (hit_ctrl) begin
         next_prdata[`TLI_CTRL_W-1:0] = ctrl;
      end else if (hit_stat) begin
         next_prdata[`TLI_ST_PINS_ON] = st_sync[`TLI_ST_PINS_ON];
         next_prdata[`TLI_ST_REF_SEEN] = ref_seen;
      end
   end

   // Read data registered in setup so it is stable through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   // Rate select straight from the standard bit
   assign line_rate_e3 = ctrl.std_e3; // R02

   // ---------------- Reference clock ----------------
   logic ref_clk;   // Selected, possibly inverted reference
   logic fall_edge; // Update on falling edge of the source

   // Line clock source follows its own inversion; others use ref_inv
   assign fall_edge = (ctrl.ref_sel == TLI_REF_LINE) ? ctrl.clk_inv : ctrl.ref_inv; // R06

   tli_clk_mux u_mux (
      .line_clk(line_clk),
      .tx_clk_out(tx_clk_out),
      .tx_clk_in(tx_clk_in),
      .rx_line_clk_in(rx_line_clk_in),
      .rx_clk_out(rx_clk_out),
      .sel(ctrl.ref_sel),
      .fall(fall_edge),
      .ref_clk(ref_clk)
   ); // R07

   // ---------------- Link side ----------------
   logic [1:0] lrst_pipe; // Reset release synchroniser
   logic lrst_n;          // Link reset, released on reference edge
   tli_ctrl_t lcfg;       // Control seen in link domain
   logic alive;           // Toggles every reference edge
   logic pos_q;           // Positive/data output flop
   logic neg_q;           // Negative output flop
   logic drive_q;         // Analog drive allowed
   logic next_pos;        // Next positive/data value
   logic next_neg;        // Next negative value
   logic pos_idle;        // Inactive level of positive pin
   logic neg_idle;        // Inactive level of negative pin
   logic pos_off;         // Positive/data output disabled

   // Reset asserts at once, releases on the reference clock
   always_ff @(posedge ref_clk or negedge presetn) begin
      if (!presetn) begin
         lrst_pipe <= 2'b00;
      end else begin
         lrst_pipe <= {lrst_pipe[0], 1'b1};
      end
   end
   assign lrst_n = lrst_pipe[1];

   // Config levels into link domain
   tli_sync #(.WIDTH(`TLI_CTRL_W)) u_cfg_sync (
      .clk(ref_clk),
      .rst_n(lrst_n),
      .d(ctrl),
      .q(lcfg)
   );

   // Status levels back to APB domain
   tli_sync #(.WIDTH(`TLI_ST_W)) u_st_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({alive, lcfg.pins_en}),
      .q(st_sync)
   );

   // Inactive levels follow inversion so the pin rests deasserted
   assign pos_idle = lcfg.pos_inv; // R08 R12
   assign neg_idle = lcfg.neg_inv; // R08 R12
   assign pos_off = lcfg.line_unit_en && lcfg.pos_dis; // R09

   // Next pulse/data values
   always_comb begin
      next_pos = pos_idle;
      next_neg = neg_idle;
      if (lcfg.pins_en && !pos_off) begin
         if (lcfg.mode == TLI_MODE_UNIPOLAR) begin
            next_pos = line_in.data ^ lcfg.pos_inv; // R05
         end else begin
            next_pos = line_in.pos ^ lcfg.pos_inv; // R03
         end
      end
      if (lcfg.pins_en && lcfg.mode != TLI_MODE_UNIPOLAR) begin
         next_neg = line_in.neg ^ lcfg.neg_inv; // R04
      end
   end

   // Output flops update on the chosen reference edge
   always_ff @(posedge ref_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         pos_q <= 1'b0;
         neg_q <= 1'b0;
      end else begin
         pos_q <= next_pos; // R06
         neg_q <= next_neg; // R06
      end
   end

   // Analog driver enable and activity toggle
   always_ff @(posedge ref_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         drive_q <= 1'b0;
         alive <= 1'b0;
      end else begin
         drive_q <= lcfg.line_unit_en && lcfg.drive_en; // R10
         alive <= !alive;
      end
   end

   // Frame inputs caught on the same edge as the line outputs
   always_ff @(posedge ref_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         frame_out <= '0;
      end else begin
         frame_out <= '{frame_start: tx_frame_start_in, serial_data: tx_serial_data_in}; // R11
      end
   end

   assign tx_pos_pulse_out = pos_q;
   assign tx_neg_pulse_out = neg_q;
   // Analog pair carries the pulse state, high impedance unless driving
   assign tx_analog_plus = pos_q ^ lcfg.pos_inv;
   assign tx_analog_minus = neg_q ^ lcfg.neg_inv;
   assign tx_analog_plus_oe_n = !drive_q; // R10
   assign tx_analog_minus_oe_n = !drive_q; // R10

   // Line clock gated by the pin enable; gate may clip one phase on toggle
   assign tx_line_clk_out = lcfg.pins_en ? (line_clk ^ lcfg.clk_inv) : lcfg.clk_inv; // R01 R08 R12

   // ---------------- Checks ----------------
   // Unmapped access answers with an error
   property p_unmapped;
      @(posedge pclk) disable iff (!presetn)
         (psel && penable && !hit_ctrl && !hit_stat) |-> (pslverr && pready);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access without error"); // APB map

   // Pins disabled: outputs rest idle from next edge
   property p_pins_off;
      @(posedge ref_clk) disable iff (!lrst_n)
         !lcfg.pins_en |=> (pos_q == $past(pos_idle)) && (neg_q == $past(neg_idle));
   endproperty
   a_pins_off: assert property (p_pins_off) else $error("disabled pins not idle"); // R12

   // Positive pulse follows the encoder one edge later
   property p_pos;
      @(posedge ref_clk) disable iff (!lrst_n)
         (lcfg.pins_en && !pos_off && lcfg.mode != TLI_MODE_UNIPOLAR)
            |=> pos_q == ($past(line_in.pos) ^ $past(lcfg.pos_inv));
   endproperty
   a_pos: assert property (p_pos) else $error("positive pulse mismatch"); // R03

   // Negative pulse follows the encoder one edge later
   property p_neg;
      @(posedge ref_clk) disable iff (!lrst_n)
         (lcfg.pins_en && lcfg.mode != TLI_MODE_UNIPOLAR)
            |=> neg_q == ($past(line_in.neg) ^ $past(lcfg.neg_inv));
   endproperty
   a_neg: assert property (p_neg) else $error("negative pulse mismatch"); // R04

   // Unipolar carries unencoded data
   property p_uni;
      @(posedge ref_clk) disable iff (!lrst_n)
         (lcfg.pins_en && !pos_off && lcfg.mode == TLI_MODE_UNIPOLAR)
            |=> pos_q == ($past(line_in.data) ^ $past(lcfg.pos_inv));
   endproperty
   a_uni: assert property (p_uni) else $error("unipolar data mismatch"); // R05

   // Disabled positive/data pin stays idle
   property p_pos_off;
      @(posedge ref_clk) disable iff (!lrst_n)
         pos_off |=> pos_q == $past(pos_idle);
   endproperty
   a_pos_off: assert property (p_pos_off) else $error("disabled positive pin moved"); // R09

   // Two steps: drive requested, then analog enabled next edge
   sequence s_drive_req;
      lcfg.line_unit_en && lcfg.drive_en;
   endsequence
   sequence s_drive_on;
      !tx_analog_plus_oe_n && !tx_analog_minus_oe_n;
   endsequence
   property p_drive;
      @(posedge ref_clk) disable iff (!lrst_n)
         s_drive_req ##1 s_drive_req |-> s_drive_on;
   endproperty
   a_drive: assert property (p_drive) else $error("analog not driven"); // R10

   // No drive request: high impedance next edge
   property p_hiz;
      @(posedge ref_clk) disable iff (!lrst_n)
         !(lcfg.line_unit_en && lcfg.drive_en) |=> (tx_analog_plus_oe_n && tx_analog_minus_oe_n);
   endproperty
   a_hiz: assert property (p_hiz) else $error("analog driven while off"); // R10

   // Frame-start input registered on the reference edge
   property p_frame;
      @(posedge ref_clk) disable iff (!lrst_n)
         1'b1 |=> frame_out.frame_start == $past(tx_frame_start_in);
   endproperty
   a_frame: assert property (p_frame) else $error("frame start not caught"); // R11

endmodule // tli_top

/* File: tli_liu_model.sv */
// Purpose: Line interface unit model at the far side of the port
// Assumes: Pulses are launched on one line clock edge and held a bit period
// Notes: Samples mid bit, on the falling edge of the line clock it receives
module tli_line_unit_model (
   input wire logic lclk, // Line clock from the port
   input wire logic pos,  // Positive pulse pin
   input wire logic neg,  // Negative pulse pin
   output int pos_cnt,    // Positive pulses seen
   output int neg_cnt,    // Negative pulses seen
   output int both_cnt    // Both pulses at once, a coding fault
);
   timeunit 1ns;
   timeprecision 100ps;
   // Counters start clean so the bench can take deltas
   initial begin
      pos_cnt = 0;
      neg_cnt = 0;
      both_cnt = 0;
   end
   // Mid-bit sample keeps clear of the launch edge
   always @(negedge lclk) begin
      if (pos === 1'b1) pos_cnt <= pos_cnt + 1;
      if (neg === 1'b1) neg_cnt <= neg_cnt + 1;
      if (pos === 1'b1 && neg === 1'b1) both_cnt <= both_cnt + 1;
   end
endmodule // tli_line_unit_model

/* File: tx_line_interface_output_tb_top.sv */
// Purpose: Self-checking bench for the transmit line interface output stage
// Assumes: Encoder bits and frame inputs are driven on the selected reference edge
// Notes: Reference source is changed in the same write that disables the pins
`include "tli_defs.svh"
module tx_line_interface_output_tb_top
   import tli_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk, presetn, psel, penable, pwrite; // APB side
   logic [`TLI_ADDR_W-1:0] paddr; // Byte address
   logic [31:0] pwdata, prdata; // Data words
   logic pready, pslverr; // Slave answer
   logic line_clk, tx_clk_out, tx_clk_in, rx_line_clk_in, rx_clk_out; // Reference sources
   tli_line_t line_in; // Encoder bits
   logic tx_frame_start_in, tx_serial_data_in; // Frame inputs
   tli_frame_t frame_out; // Caught frame inputs
   logic line_rate_e3, tx_line_clk_out, tx_pos_pulse_out, tx_neg_pulse_out; // Line pins
   logic tx_analog_plus, tx_analog_plus_oe_n, tx_analog_minus, tx_analog_minus_oe_n; // Analog pair
   int miscompares, check_count, pcnt, ncnt, bcnt, p0, n0; // Bookkeeping
   tli_ctrl_t cfg; // Control image under test
   // APB clock
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Link clock and alternates, unrelated in phase
   always #62.5 line_clk = ~line_clk;
   always #55 tx_clk_out = ~tx_clk_out;
   always #65.3 tx_clk_in = ~tx_clk_in;
   always #70.1 rx_line_clk_in = ~rx_line_clk_in;
   always #58.7 rx_clk_out = ~rx_clk_out;
   tli_top u_tli_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .line_clk, .tx_clk_out, .tx_clk_in, .rx_line_clk_in, .rx_clk_out, .line_in,
      .tx_frame_start_in, .tx_serial_data_in, .frame_out, .line_rate_e3, .tx_line_clk_out,
      .tx_pos_pulse_out, .tx_neg_pulse_out, .tx_analog_plus, .tx_analog_plus_oe_n,
      .tx_analog_minus, .tx_analog_minus_oe_n);
   tli_line_unit_model u_tli_line_unit_model (.lclk(tx_line_clk_out), .pos(tx_pos_pulse_out),
      .neg(tx_neg_pulse_out), .pos_cnt(pcnt), .neg_cnt(ncnt), .both_cnt(bcnt));
   // Comparison shared by every scenario
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (miscompares == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         miscompares++;
         give_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Wait for the edge that launches the outputs
   task automatic ref_edge();
      logic f;
      f = (cfg.ref_sel == TLI_REF_LINE) ? cfg.clk_inv : cfg.ref_inv;
      case (cfg.ref_sel)
         TLI_REF_TXO: if (f) @(negedge tx_clk_out); else @(posedge tx_clk_out);
         TLI_REF_TXI: if (f) @(negedge tx_clk_in); else @(posedge tx_clk_in);
         TLI_REF_RXL: if (f) @(negedge rx_line_clk_in); else @(posedge rx_line_clk_in);
         TLI_REF_RXO: if (f) @(negedge rx_clk_out); else @(posedge rx_clk_out);
         default: if (f) @(negedge line_clk); else @(posedge line_clk);
      endcase
   endtask
   // Pins go off in the same write that loads the new source, then take cfg.pins_en; the source mux is not glitch free
   task automatic set_cfg();
      logic [31:0] rd;
      logic e;
      apb(1'b1, `TLI_OFS_CTRL, {18'h0, cfg} & 32'h00003ffe, rd, e);
      apb(1'b1, `TLI_OFS_CTRL, {18'h0, cfg}, rd, e);
      apb(1'b0, `TLI_OFS_CTRL, 32'h0, rd, e);
      chk(rd, {18'h0, cfg});
      repeat (4) ref_edge();
   endtask
   function automatic tli_line_t pat(input int i);
      return '{pos: (i % 3 == 1), neg: (i % 3 == 2), data: i[0] ^ i[2]};
   endfunction
   // Output pins against one bit launched an edge earlier
   task automatic judge(input tli_line_t b, input int j);
      logic ep, en, drv;
      drv = cfg.line_unit_en & cfg.drive_en;
      ep = (cfg.mode == TLI_MODE_UNIPOLAR) ? b.data : b.pos;
      if (cfg.pos_dis & cfg.line_unit_en) ep = 1'b0;
      en = (cfg.mode == TLI_MODE_UNIPOLAR) ? 1'b0 : b.neg;
      chk(tx_pos_pulse_out, ep ^ cfg.pos_inv);
      chk(tx_neg_pulse_out, en ^ cfg.neg_inv);
      chk(frame_out, {j[0], j[1]});
      chk(tx_line_clk_out, line_clk ^ cfg.clk_inv);
      chk({tx_analog_plus_oe_n, tx_analog_minus_oe_n}, drv ? 2'b00 : 2'b11);
      if (drv && !cfg.pos_dis && cfg.mode != TLI_MODE_UNIPOLAR) chk({tx_analog_plus, tx_analog_minus}, {b.pos, b.neg});
   endtask
   // Continuous stream, driven and judged edge by edge
   task automatic stream(input int n);
      for (int i = 0; i <= n; i++) begin
         ref_edge();
         line_in <= (i < n) ? pat(i) : '0;
         tx_frame_start_in <= i[0];
         tx_serial_data_in <= i[1];
         #1;
         if (i > 0) judge(pat(i - 1), i - 1);
      end
      repeat (2) ref_edge();
   endtask
   // Disabled pins stand still at the inversion level
   task automatic idle_check();
      repeat (3) begin
         @(posedge line_clk);
         #1;
         chk(tx_line_clk_out, cfg.clk_inv);
         chk(tx_pos_pulse_out, cfg.pos_inv);
         chk(tx_neg_pulse_out, cfg.neg_inv);
         chk({tx_analog_plus_oe_n, tx_analog_minus_oe_n}, 2'b11);
         @(negedge line_clk);
         #1;
         chk(tx_line_clk_out, cfg.clk_inv);
      end
   endtask
   // Cuts a hang short
   initial begin
      #500us;
      miscompares++;
      give_verdict();
   end
   // Main sequence
   initial begin
      logic [31:0] rd;
      logic e;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {line_clk, tx_clk_out, tx_clk_in, rx_line_clk_in, rx_clk_out} = '0;
      {line_in, tx_frame_start_in, tx_serial_data_in} = '0;
      miscompares = 0;
      check_count = 0;
      cfg = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // Reset state, reserved bits and an unmapped word
      idle_check();
      apb(1'b1, `TLI_OFS_CTRL, 32'hffffc000, rd, e);
      apb(1'b0, `TLI_OFS_CTRL, 32'h0, rd, e);
      chk(rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0, rd, e);
      chk(e, 1'b1);
      chk(rd, 32'h0);
      // Every line coding on the default reference
      for (int m = 0; m < 4; m++) begin
         cfg = '0;
         cfg.pins_en = 1'b1;
         cfg.mode = tli_mode_t'(m);
         set_cfg();
         p0 = pcnt;
         n0 = ncnt;
         stream(8);
         if (m < 3) chk(pcnt - p0, 3);
         if (m < 3) chk(ncnt - n0, 2);
      end
      chk(bcnt, 0);
      // Inversion, then disable with the inversion still set
      cfg.mode = TLI_MODE_AMI;
      {cfg.clk_inv, cfg.pos_inv, cfg.neg_inv} = 3'b111;
      set_cfg();
      stream(8);
      cfg.pins_en = 1'b0;
      set_cfg();
      idle_check();
      // Each alternate reference, odd codes on the falling edge, even codes on the rising edge
      for (int s = 1; s < 5; s++) begin
         cfg = '0;
         cfg.pins_en = 1'b1;
         cfg.mode = TLI_MODE_HDB3;
         cfg.ref_sel = tli_ref_t'(s);
         cfg.ref_inv = s[0];
         set_cfg();
         stream(6);
      end
      // Internal unit: drive off, drive on, positive pin disabled
      cfg = '0;
      cfg.pins_en = 1'b1;
      cfg.mode = TLI_MODE_AMI;
      cfg.line_unit_en = 1'b1;
      for (int k = 0; k < 3; k++) begin
         cfg.drive_en = (k > 0);
         cfg.pos_dis = (k == 2);
         set_cfg();
         stream(6);
      end
      // Rate select and status of the link side
      cfg.std_e3 = 1'b1;
      set_cfg();
      chk(line_rate_e3, 1'b1);
      apb(1'b0, `TLI_OFS_STATUS, 32'h0, rd, e);
      chk(rd, 32'h3);
      cfg.std_e3 = 1'b0;
      set_cfg();
      chk(line_rate_e3, 1'b0);
      give_verdict();
   end
endmodule // tx_line_interface_output_tb_top
